/* src/ifmp_top.sv */
// Module: lower interrupt request, mask and priority bank with APB register access
`timescale 1ns/1ps
// How it works
// - Flag reads 1 while request pending, 0 otherwise; writing 0 clears it
// - Mask 0 lets a pending request be served; mask 1 blocks, flag kept
// - Two priority bits per source: 00 highest level 0, 11 lowest level 3
// - Flag register: watchdog interval at bit 0, external pin 0 at bit 1
// - Mask register mirrors flags: watchdog at bit 0, pin 0 at bit 1
// - Low and high priority banks use the same layout as the flags
// - Pin edge select: none, rising, falling or both from two enable bits
module ifmp_top (
   // Clock and reset
   input  wire logic                          REF_CLK_I,
   input  wire logic                          SRST_I,
   // APB slave
   input  wire logic                          PSEL_I,
   input  wire logic                          PENABLE_I,
   input  wire logic                          PWRITE_I,
   input  wire logic [ifmp_pkg::ADDR_W-1:0]   PADDR_I,
   input  wire logic [ifmp_pkg::DATA_W-1:0]   PWDATA_I,
   output logic      [ifmp_pkg::DATA_W-1:0]   PRDATA_O,
   output logic                               PREADY_O,
   output logic                               PSLVERR_O,
   // Interrupt sources
   input  wire logic                          WDT_INTERVAL_I,
   input  wire logic                          PIN0_I,
   // Processor core
   input  wire logic                          INTACK_I,
   output logic                               INTREQ_O,
   output logic      [0:0]                    INTSRC_O,
   output logic      [1:0]                    INTLVL_O,
   // Event interrupt
   output logic                               IRQ_O
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   ifmp_pkg::ifmp_apb_st_t             st_r;
   logic [ifmp_pkg::DATA_W-1:0]        prdata_r;
   logic                               pready_r;
   logic                               pslverr_r;
   logic [ifmp_pkg::REG_W-1:0]         flags_r;
   logic [ifmp_pkg::REG_W-1:0]         flags_nxt;
   logic [ifmp_pkg::REG_W-1:0]         mask_r;
   logic [ifmp_pkg::REG_W-1:0]         prlo_r;
   logic [ifmp_pkg::REG_W-1:0]         prhi_r;
   logic [1:0]                         edge_ctrl_r;
   logic [ifmp_pkg::NUM_SRC-1:0]       evt_st_r;
   logic [ifmp_pkg::NUM_SRC-1:0]       evt_st_nxt;
   logic [ifmp_pkg::NUM_SRC-1:0]       evt_en_r;
   logic [ifmp_pkg::NUM_SRC-1:0]       hw_set;
   logic                               irq_r;
   logic                               pin_edge;
   logic                               wr_fire;
   logic                               rd_take;
   logic [ifmp_pkg::DATA_W-1:0]        rd_val;
   logic                               rd_hit;
   ifmp_pkg::ifmp_pres_t               pres;

   // One decode used by the write enables and by the read mux
   function automatic logic reg_hit(input logic [ifmp_pkg::ADDR_W-1:0] a,
                                    input logic [ifmp_pkg::ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction

   function automatic logic wr_to(input logic                         fire,
                                  input logic [ifmp_pkg::ADDR_W-1:0] a,
                                  input logic [ifmp_pkg::ADDR_W-1:0] ofs);
      return fire && reg_hit(a, ofs);
   endfunction

   // ***************************************************************
   // APB slave: one wait state, write lands at the ready edge
   // ***************************************************************
   assign rd_take = (st_r == ifmp_pkg::ST_IDLE) && PSEL_I && PENABLE_I;
   assign wr_fire = PSEL_I && PENABLE_I && PWRITE_I && pready_r && !pslverr_r;

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         st_r      <= ifmp_pkg::ST_IDLE;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= '0;
      end else begin
         case (st_r)
            ifmp_pkg::ST_IDLE: begin
               if (rd_take) begin
                  st_r      <= ifmp_pkg::ST_RESP;
                  pready_r  <= 1'b1;
                  pslverr_r <= !rd_hit;
                  prdata_r  <= PWRITE_I ? '0 : rd_val;
               end
            end
            ifmp_pkg::ST_RESP: begin
               st_r      <= ifmp_pkg::ST_IDLE;
               pready_r  <= 1'b0;
               pslverr_r <= 1'b0;
               prdata_r  <= '0;
            end
            default: begin
               st_r     <= ifmp_pkg::ST_IDLE;
               pready_r <= 1'b0;
            end
         endcase
      end
   end

   // Unmapped addresses read zero and answer with an error
   always_comb begin
      rd_val = '0;
      rd_hit = 1'b1;
      if (reg_hit(PADDR_I, ifmp_pkg::OFS_REQ_FLAGS)) begin
         rd_val[ifmp_pkg::REG_W-1:0] = flags_r;
      end else if (reg_hit(PADDR_I, ifmp_pkg::OFS_MASK_FLAGS)) begin
         rd_val[ifmp_pkg::REG_W-1:0] = mask_r;
      end else if (reg_hit(PADDR_I, ifmp_pkg::OFS_PRIO_LOW)) begin
         rd_val[ifmp_pkg::REG_W-1:0] = prlo_r;
      end else if (reg_hit(PADDR_I, ifmp_pkg::OFS_PRIO_HIGH)) begin
         rd_val[ifmp_pkg::REG_W-1:0] = prhi_r;
      end else if (reg_hit(PADDR_I, ifmp_pkg::OFS_EDGE_CTRL)) begin
         rd_val[1:0] = edge_ctrl_r;
      end else if (reg_hit(PADDR_I, ifmp_pkg::OFS_EVT_STATUS)) begin
         rd_val[ifmp_pkg::NUM_SRC-1:0] = evt_st_r;
      end else if (reg_hit(PADDR_I, ifmp_pkg::OFS_EVT_ENABLE)) begin
         rd_val[ifmp_pkg::NUM_SRC-1:0] = evt_en_r;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // ***************************************************************
   // Source events
   // ***************************************************************
   ifmp_edge_det u_edge (
      .clk_i     (REF_CLK_I),
      .srst_i    (SRST_I),
      .pin_i     (PIN0_I),
      .rise_en_i (edge_ctrl_r[ifmp_pkg::BIT_RISE_EN]),
      .fall_en_i (edge_ctrl_r[ifmp_pkg::BIT_FALL_EN]),
      .edge_o    (pin_edge)
   );

   always_comb begin
      hw_set                     = '0;
      hw_set[ifmp_pkg::BIT_WDT]  = WDT_INTERVAL_I;
      hw_set[ifmp_pkg::BIT_PIN0] = pin_edge;
   end

   // ***************************************************************
   // Request flags: write, then acknowledge, then hardware set wins
   // ***************************************************************
   always_comb begin
      flags_nxt = flags_r;
      if (wr_to(wr_fire, PADDR_I, ifmp_pkg::OFS_REQ_FLAGS)) begin
         flags_nxt = PWDATA_I[ifmp_pkg::REG_W-1:0];
      end
      if (INTACK_I && INTREQ_O) begin
         flags_nxt[INTSRC_O] = 1'b0;
      end
      flags_nxt[ifmp_pkg::NUM_SRC-1:0] = flags_nxt[ifmp_pkg::NUM_SRC-1:0] | hw_set;
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         flags_r <= ifmp_pkg::RST_REQ_FLAGS;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // ***************************************************************
   // Mask, priority and edge control registers
   // ***************************************************************
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         mask_r <= ifmp_pkg::RST_MASK_FLAGS;
      end else if (wr_to(wr_fire, PADDR_I, ifmp_pkg::OFS_MASK_FLAGS)) begin
         mask_r <= PWDATA_I[ifmp_pkg::REG_W-1:0];
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         prlo_r <= ifmp_pkg::RST_PRIO;
         prhi_r <= ifmp_pkg::RST_PRIO;
      end else begin
         if (wr_to(wr_fire, PADDR_I, ifmp_pkg::OFS_PRIO_LOW)) begin
            prlo_r <= PWDATA_I[ifmp_pkg::REG_W-1:0];
         end
         if (wr_to(wr_fire, PADDR_I, ifmp_pkg::OFS_PRIO_HIGH)) begin
            prhi_r <= PWDATA_I[ifmp_pkg::REG_W-1:0];
         end
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         edge_ctrl_r <= ifmp_pkg::RST_EDGE_CTRL;
      end else if (wr_to(wr_fire, PADDR_I, ifmp_pkg::OFS_EDGE_CTRL)) begin
         edge_ctrl_r <= PWDATA_I[1:0];
      end
   end

   // ***************************************************************
   // Priority selection toward the core
   // ***************************************************************
   ifmp_prio_sel u_prio (
      .clk_i   (REF_CLK_I),
      .srst_i  (SRST_I),
      .flags_i (flags_r[ifmp_pkg::NUM_SRC-1:0]),
      .mask_i  (mask_r[ifmp_pkg::NUM_SRC-1:0]),
      .prlo_i  (prlo_r[ifmp_pkg::NUM_SRC-1:0]),
      .prhi_i  (prhi_r[ifmp_pkg::NUM_SRC-1:0]),
      .pres_o  (pres)
   );

   // ***************************************************************
   // Event status, enable and level interrupt
   // ***************************************************************
   // An event in the clearing cycle survives: set is applied last
   always_comb begin
      evt_st_nxt = evt_st_r;
      if (wr_to(wr_fire, PADDR_I, ifmp_pkg::OFS_EVT_STATUS)) begin
         evt_st_nxt = evt_st_r & ~PWDATA_I[ifmp_pkg::NUM_SRC-1:0];
      end
      evt_st_nxt = evt_st_nxt | hw_set;
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         evt_st_r <= ifmp_pkg::RST_EVT;
         evt_en_r <= ifmp_pkg::RST_EVT;
         irq_r    <= 1'b0;
      end else begin
         evt_st_r <= evt_st_nxt;
         if (wr_to(wr_fire, PADDR_I, ifmp_pkg::OFS_EVT_ENABLE)) begin
            evt_en_r <= PWDATA_I[ifmp_pkg::NUM_SRC-1:0];
         end
         irq_r <= |(evt_st_r & evt_en_r);
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign PRDATA_O  = prdata_r;
   assign PREADY_O  = pready_r;
   assign PSLVERR_O = pslverr_r;
   assign INTREQ_O  = pres.valid;
   assign INTSRC_O  = pres.src;
   assign INTLVL_O  = pres.lvl;
   assign IRQ_O     = irq_r;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SRST_I);

   a_wdt_flag_set: assert property (WDT_INTERVAL_I |=> flags_r[ifmp_pkg::BIT_WDT])
      else $error("Watchdog event did not set its flag");
   a_pin_flag_set: assert property (pin_edge |=> flags_r[ifmp_pkg::BIT_PIN0] ##1
      flags_r[ifmp_pkg::BIT_PIN0] || $past(wr_fire) || $past(INTACK_I))
      else $error("Pin flag not set or dropped by itself");
   a_flag_sw_clear: assert property (wr_to(wr_fire, PADDR_I, ifmp_pkg::OFS_REQ_FLAGS)
      && !PWDATA_I[ifmp_pkg::BIT_WDT] && !WDT_INTERVAL_I |=> !flags_r[ifmp_pkg::BIT_WDT])
      else $error("Writing zero did not clear the flag");
   // The presented source is judged by the flags and masks of the cycle before
   a_mask_blocks: assert property (INTREQ_O |->
      (INTSRC_O ? $past(flags_r[ifmp_pkg::BIT_PIN0] && !mask_r[ifmp_pkg::BIT_PIN0])
                : $past(flags_r[ifmp_pkg::BIT_WDT] && !mask_r[ifmp_pkg::BIT_WDT])))
      else $error("Masked or idle source presented");
   a_mask_bit0: assert property (flags_r[ifmp_pkg::BIT_WDT] && !mask_r[ifmp_pkg::BIT_WDT]
      |=> INTREQ_O)
      else $error("Unmasked watchdog request not presented");
   a_level_map: assert property (INTREQ_O |-> INTLVL_O == (INTSRC_O ?
      $past({prhi_r[ifmp_pkg::BIT_PIN0], prlo_r[ifmp_pkg::BIT_PIN0]}) :
      $past({prhi_r[ifmp_pkg::BIT_WDT], prlo_r[ifmp_pkg::BIT_WDT]})))
      else $error("Presented level does not match priority bits");
   a_tie_order: assert property (&(flags_r[1:0] & ~mask_r[1:0]) &&
      prlo_r[0] == prlo_r[1] && prhi_r[0] == prhi_r[1] |=> INTSRC_O == 1'b0)
      else $error("Tie not resolved to the watchdog source");
   a_best_level: assert property (&(flags_r[1:0] & ~mask_r[1:0]) &&
      {prhi_r[1], prlo_r[1]} < {prhi_r[0], prlo_r[0]} |=> INTSRC_O == 1'b1)
      else $error("Higher priority pin request not chosen");
   a_apb_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
      else $error("APB answer later than one wait state");
   a_irq_level: assert property (|(evt_st_r & evt_en_r) |=> IRQ_O)
      else $error("Enabled event did not raise the interrupt");

   c_wdt_served: cover property (WDT_INTERVAL_I ##[1:4] INTREQ_O && INTSRC_O == 1'b0);
   c_pin_served: cover property (pin_edge ##[1:4] INTREQ_O && INTSRC_O == 1'b1);
   c_both_pending: cover property (INTREQ_O && &flags_r[1:0]);
   c_apb_error: cover property (PSLVERR_O && PREADY_O);

endmodule

/* src/ifmp_pkg.sv */
// Package: register map, field positions, reset values and types of the interrupt bank
package ifmp_pkg;

   // ***************************************************************
   // Register map (byte addresses on the APB)
   // ***************************************************************
   localparam int         ADDR_W          = 8;
   localparam int         DATA_W          = 32;
   localparam int         REG_W           = 8;
   localparam int         NUM_SRC         = 2;
   localparam logic [7:0] OFS_REQ_FLAGS   = 8'h00;
   localparam logic [7:0] OFS_MASK_FLAGS  = 8'h04;
   localparam logic [7:0] OFS_PRIO_LOW    = 8'h08;
   localparam logic [7:0] OFS_PRIO_HIGH   = 8'h0c;
   localparam logic [7:0] OFS_EDGE_CTRL   = 8'h10;
   localparam logic [7:0] OFS_EVT_STATUS  = 8'h14;
   localparam logic [7:0] OFS_EVT_ENABLE  = 8'h18;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int         BIT_WDT         = 0;
   localparam int         BIT_PIN0        = 1;
   localparam int         BIT_RISE_EN     = 0;
   localparam int         BIT_FALL_EN     = 1;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [7:0] RST_REQ_FLAGS   = 8'h00;
   localparam logic [7:0] RST_MASK_FLAGS  = 8'hff;
   localparam logic [7:0] RST_PRIO        = 8'hff;
   localparam logic [1:0] RST_EDGE_CTRL   = 2'h0;
   localparam logic [1:0] RST_EVT         = 2'h0;
   localparam logic [1:0] LVL_LOWEST      = 2'h3;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef struct packed {
      logic       valid;
      logic [0:0] src;
      logic [1:0] lvl;
   } ifmp_pres_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RESP = 2'b10
   } ifmp_apb_st_t;

endpackage

/* src/ifmp_edge_det.sv */
// Module: pin synchroniser and selectable edge detector for the external pin interrupt
`timescale 1ns/1ps
module ifmp_edge_det (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic srst_i,
   // Pin and edge selection
   input  wire logic pin_i,
   input  wire logic rise_en_i,
   input  wire logic fall_en_i,
   // Detected edge
   output logic      edge_o
);

   logic sync1_r;
   logic sync2_r;
   logic prev_r;
   logic edge_r;

   // ***************************************************************
   // Synchroniser, first stage read only by the second
   // ***************************************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r  <= 1'b0;
      end else begin
         sync1_r <= pin_i;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   // ***************************************************************
   // Edge selection: none, rising, falling or both
   // ***************************************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         edge_r <= 1'b0;
      end else begin
         edge_r <= (rise_en_i & sync2_r & ~prev_r) | (fall_en_i & ~sync2_r & prev_r);
      end
   end

   assign edge_o = edge_r;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   a_edge_rise: assert property (rise_en_i && sync2_r && !prev_r |=> edge_r)
      else $error("Rising edge missed");
   a_edge_fall: assert property (fall_en_i && !sync2_r && prev_r |=> edge_r)
      else $error("Falling edge missed");
   a_edge_off: assert property (!rise_en_i && !fall_en_i |=> !edge_r)
      else $error("Edge reported while detection disabled");

endmodule

/* src/ifmp_prio_sel.sv */
// Module: priority selection among flagged and unmasked requests
`timescale 1ns/1ps
module ifmp_prio_sel (
   // Clock and reset
   input  wire logic                             clk_i,
   input  wire logic                             srst_i,
   // Request state
   input  wire logic [ifmp_pkg::NUM_SRC-1:0]     flags_i,
   input  wire logic [ifmp_pkg::NUM_SRC-1:0]     mask_i,
   input  wire logic [ifmp_pkg::NUM_SRC-1:0]     prlo_i,
   input  wire logic [ifmp_pkg::NUM_SRC-1:0]     prhi_i,
   // Presented request
   output ifmp_pkg::ifmp_pres_t                  pres_o
);

   ifmp_pkg::ifmp_pres_t pres_r;
   ifmp_pkg::ifmp_pres_t pick;

   // Lower source index wins a tie, so the watchdog goes before the pin
   function automatic ifmp_pkg::ifmp_pres_t pick_best(
      input logic [ifmp_pkg::NUM_SRC-1:0] fl,
      input logic [ifmp_pkg::NUM_SRC-1:0] mk,
      input logic [ifmp_pkg::NUM_SRC-1:0] lo,
      input logic [ifmp_pkg::NUM_SRC-1:0] hi);
      ifmp_pkg::ifmp_pres_t best;
      logic [1:0]           lvl;
      best       = '0;
      best.lvl   = ifmp_pkg::LVL_LOWEST;
      for (int i = 0; i < ifmp_pkg::NUM_SRC; i++) begin
         lvl = {hi[i], lo[i]};
         if (fl[i] && !mk[i] && (!best.valid || lvl < best.lvl)) begin
            best.valid = 1'b1;
            best.src   = i[0:0];
            best.lvl   = lvl;
         end
      end
      return best;
   endfunction

   always_comb begin
      pick = pick_best(flags_i, mask_i, prlo_i, prhi_i);
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pres_r <= '0;
      end else begin
         pres_r <= pick;
      end
   end

   assign pres_o = pres_r;

endmodule

/* tb/ifmp_core_model.sv */
// Partner model: processor core that acknowledges a presented request
`timescale 1ns/1ps
module ifmp_core_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   // Behaviour control
   input  wire logic       ack_en_i,
   input  wire logic [3:0] dly_i,
   // Interrupt handshake
   input  wire logic       intreq_i,
   output logic            intack_o
);
   // ***************************************************************
   // One acknowledge per presentation while dly_i is below 15, dly_i + 1 cycles after the request rises
   // ***************************************************************
   logic [3:0] cnt_r;

   // Counter saturates so a request that stays up is acked only once while dly_i is below 15
   always_ff @(posedge clk_i) begin
      if (srst_i || !ack_en_i || !intreq_i) begin
         cnt_r    <= 4'h0;
         intack_o <= 1'b0;
      end else begin
         intack_o <= (cnt_r == dly_i);
         cnt_r    <= (cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1;
      end
   end
endmodule

/* tb/ifmp_tb.sv */
// Testbench: registers, presentation, priority and pin edges of the interrupt bank
`timescale 1ns/1ps
module ifmp_tb;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        wdt = 1'b0;
   logic        pin = 1'b0;
   logic        intack;
   logic        intreq;
   logic [0:0]  intsrc;
   logic [1:0]  intlvl;
   logic        irq;
   logic        ack_en = 1'b0;
   logic [3:0]  dly = 4'h0;
   logic [31:0] q;
   logic        e;
   logic [2:0]  p;
   logic [31:0] rv [7] = '{32'h0, 32'hff, 32'hff, 32'hff, 32'h0, 32'h0, 32'h0};
   int          failures = 0;
   int          num_checks = 0;
   int          seed = 13;
   int          n;

   always #20 clk = ~clk;

   ifmp_top ifmp_top_i (.REF_CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .WDT_INTERVAL_I(wdt), .PIN0_I(pin),
      .INTACK_I(intack), .INTREQ_O(intreq), .INTSRC_O(intsrc), .INTLVL_O(intlvl),
      .IRQ_O(irq));

   ifmp_core_model ifmp_core_model_i (.clk_i(clk), .srst_i(srst), .ack_en_i(ack_en),
      .dly_i(dly), .intreq_i(intreq), .intack_o(intack));

   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic stop_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex) begin
         failures++;
         $display("MISMATCH %s exp %h got %h", nm, ex, got);
      end
   endtask

   // Read data is taken at the edge where ready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // Ready is sampled at the rising edge; the request is released only after it
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
      if (k >= 20) begin
         failures++;
         stop_test();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, ex, q);
   endtask

   task automatic wt(input int c);
      repeat (c) @(posedge clk);
      @(negedge clk);
   endtask

   // Lowest level wins, watchdog first on a tie
   function automatic logic [2:0] pick(input logic [1:0] lo, input logic [1:0] hi);
      logic [1:0] l0;
      logic [1:0] l1;
      l0 = {hi[0], lo[0]};
      l1 = {hi[1], lo[1]};
      return (l1 < l0) ? {1'b1, l1} : {1'b0, l0};
   endfunction

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      stop_test();
   end

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      logic [7:0]  a;
      logic [31:0] d;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         rd(8'(4 * i), rv[i], "reset_val");
         chk("slverr", 32'h0, {31'h0, e});
      end
      rd(8'h1c, 32'h0, "unmapped_data");
      chk("unmapped_err", 32'h1, {31'h0, e});
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         a = 8'(4 * (i % 4));
         d = $random(seed);
         wr(a, d);
         rd(a, {24'h0, d[7:0]}, "reg_rw");
      end
      wr(8'h04, 32'hff);
      wr(8'h08, 32'hff);
      wr(8'h0c, 32'hff);
      wr(8'h00, 32'h0);
      rd(8'h00, 32'h0, "flag_clear");
      $display("test regs done");
      for (int r = 0; r < 2; r++) begin
         @(posedge clk);
         wdt <= 1'b1;
         dly <= r ? 4'h5 : 4'h0;
         @(posedge clk);
         wdt <= 1'b0;
         wt(3);
         chk("masked_req", 32'h0, {31'h0, intreq});
         rd(8'h00, 32'h1, "wdt_flag");
         wr(8'h04, 32'hfe);
         wr(8'h18, 32'h1);
         wt(3);
         chk("req", 32'h1, {31'h0, intreq});
         chk("src", 32'h0, {31'h0, intsrc});
         chk("lvl", 32'h3, {30'h0, intlvl});
         chk("irq", 32'h1, {31'h0, irq});
         @(posedge clk);
         ack_en <= 1'b1;
         n = 0;
         while (intreq !== 1'b0 && n < 30) begin
            @(negedge clk);
            n++;
         end
         chk("ack_drop", 32'h0, {31'h0, intreq});
         if (n >= 30) begin
            stop_test();
         end
         @(posedge clk);
         ack_en <= 1'b0;
         rd(8'h00, 32'h0, "ack_flag");
         wr(8'h14, 32'h1);
         wt(2);
         chk("irq_clr", 32'h0, {31'h0, irq});
         wr(8'h04, 32'hff);
      end
      $display("test watchdog done");
      wr(8'h00, 32'h3);
      wr(8'h04, 32'hfc);
      for (int k = 0; k < 16; k++) begin
         wr(8'h08, 32'(k % 4));
         wr(8'h0c, 32'(k / 4));
         wt(2);
         p = pick(2'(k % 4), 2'(k / 4));
         chk("prio_src", {31'h0, p[2]}, {31'h0, intsrc});
         chk("prio_lvl", {30'h0, p[1:0]}, {30'h0, intlvl});
      end
      wr(8'h04, 32'hfd);
      wt(2);
      chk("pin_src", 32'h1, {31'h0, intsrc});
      wr(8'h04, 32'hff);
      wt(2);
      chk("all_masked", 32'h0, {31'h0, intreq});
      rd(8'h00, 32'h3, "flags_kept");
      $display("test priority done");
      for (int m = 0; m < 4; m++) begin
         wr(8'h10, 32'(m));
         for (int v = 1; v >= 0; v--) begin
            wr(8'h00, 32'h0);
            @(posedge clk);
            pin <= v[0];
            wt(6);
            rd(8'h00, {30'h0, (v == 1) ? m[0] : m[1], 1'b0}, "pin_edge");
         end
      end
      $display("test pin edge done");
      stop_test();
   end
endmodule
